/* sswd_host.sv */
// Host model: toggles the strobe, hangs, or leaves the pin floating.
// Assumes mode 0 hung, 1 toggling every period_in cycles, 2 released.
module sswd_host (
	input wire logic clock_in,
	input wire logic [1:0] mode_in,
	input wire logic [9:0] period_in,
	output logic strobe_out,
	output logic float_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] cnt_q = 10'h0;
	logic level_q = 1'b0;
	always @(posedge clock_in) begin
		cnt_q <= (mode_in == 2'h1 && cnt_q + 10'h1 < period_in) ? cnt_q + 10'h1 : 10'h0;
		if (mode_in == 2'h1 && cnt_q + 10'h1 >= period_in) level_q <= ~level_q;
	end
	// A released pin does not keep its last level
	assign strobe_out = (mode_in == 2'h2) ? ~level_q : level_q;
	assign float_out = (mode_in == 2'h2);
endmodule // sswd_host

/* sswd_pkg.sv */
// Types shared by the supply supervisor files.
// Assumes sswd_regs.svh supplies the numeric constants.
package sswd_pkg;
	// ----------------------------------------
	// Reset sequencing states, Gray along the usual path
	// ----------------------------------------
	typedef enum logic [1:0] {
		SSWD_ST_SUPPLY_LOW = 2'h0,
		SSWD_ST_HOLD = 2'h1,
		SSWD_ST_RUN = 2'h3,
		SSWD_ST_WDOG_PULSE = 2'h2
	} sswd_state_t;
endpackage

/* sswd_regs.svh */
// Timing constants and encodings for the supply supervisor with watchdog.
// Assumes a 40 MHz system clock; all times are counted in clock cycles.
`ifndef SSWD_REGS_SVH
`define SSWD_REGS_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define SSWD_CLK_HZ 40000000
`define SSWD_T1_MS 50
`define SSWD_T2_MS 100
`define SSWD_T3_MS 200
`define SSWD_T4_MS 400
`define SSWD_WDOG_MS 1600
`define SSWD_MS_CYCLES (`SSWD_CLK_HZ / 1000)

// ----------------------------------------
// Timeout select encodings
// ----------------------------------------
`define SSWD_SEL_T1 2'h0
`define SSWD_SEL_T2 2'h1
`define SSWD_SEL_T3 2'h2
`define SSWD_SEL_T4 2'h3

`endif

/* sswd_supervisor.sv */
// Digital control of a triple supply supervisor with watchdog and power fail.
// Assumes comparator outputs and the strobe are asynchronous; the strobe pin
// arrives with a weak keeper sense signal telling whether it is floating.
`include "sswd_regs.svh"

// What this block does
// - Any supply low asserts reset output.
// - Hold reset for timeout after recovery.
// - All supplies good; any drop restarts timeout.
// - Timeout selectable: 50, 100, 200, 400 ms.
// - No strobe transition for the 1600 ms watchdog period triggers reset.
// - Watchdog overflow pulses reset one timeout period.
// - Floating strobe services watchdog internally.
// - Power-fail output low while sense low.
// - Reset polarity and drive type configurable.
module sswd_supervisor #(
	parameter int unsigned T1_CYCLES = `SSWD_T1_MS * `SSWD_MS_CYCLES,
	parameter int unsigned T2_CYCLES = `SSWD_T2_MS * `SSWD_MS_CYCLES,
	parameter int unsigned T3_CYCLES = `SSWD_T3_MS * `SSWD_MS_CYCLES,
	parameter int unsigned T4_CYCLES = `SSWD_T4_MS * `SSWD_MS_CYCLES,
	parameter int unsigned WDOG_CYCLES = `SSWD_WDOG_MS * `SSWD_MS_CYCLES,
	parameter int CNT_W = 27
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_in,
	// Supply comparators, high means below trip level
	input wire logic supply_one_low_in,
	input wire logic supply_two_low_in,
	input wire logic supply_three_low_in,
	// Power fail comparator, high means sense below 0.5 V
	input wire logic power_fail_sense_in,
	// Watchdog strobe and its floating detector
	input wire logic watchdog_strobe_in,
	input wire logic watchdog_float_in,
	// Manual reset request, active high
	input wire logic manual_reset_in,
	// Configuration straps
	input wire logic [1:0] timeout_select_in,
	input wire logic reset_active_high_in,
	input wire logic reset_open_drain_in,
	// Reset pin
	output logic sys_reset_out_low_out,
	output logic sys_reset_oe_out,
	output logic reset_asserted_out,
	// Power fail open-drain pin
	output logic power_fail_out_n_out,
	output logic power_fail_oe_out
);
	localparam logic [CNT_W-1:0] ONE = {{(CNT_W-1){1'b0}}, 1'b1};

	if (CNT_W < $clog2(T4_CYCLES + 1) || CNT_W < $clog2(WDOG_CYCLES + 1)) begin : g_cnt_w_check
		$error("sswd_supervisor: CNT_W too narrow for the timeouts");
	end
	if (T1_CYCLES < 1 || WDOG_CYCLES < 1) begin : g_min_check
		$error("sswd_supervisor: timeouts must be at least one cycle");
	end

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [7:0] sync_s;
	sswd_sync #(.WIDTH(8)) u_sync (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.async_in({supply_one_low_in, supply_two_low_in, supply_three_low_in, power_fail_sense_in,
			watchdog_strobe_in, watchdog_float_in, manual_reset_in, 1'b0}),
		// Supplies read as low until synchronised; power fail reads as good, so no false pull
		.reset_val_in(8'he0),
		.sync_out(sync_s)
	);

	logic any_low_s;
	logic pf_low_s;
	logic strobe_s;
	logic float_s;
	logic manual_s;
	assign any_low_s = |sync_s[7:5];
	assign pf_low_s = sync_s[4];
	assign strobe_s = sync_s[3];
	assign float_s = sync_s[2];
	assign manual_s = sync_s[1];

	// ----------------------------------------
	// Timeout selection
	// ----------------------------------------
	function automatic logic [CNT_W-1:0] sel_cycles(input logic [1:0] sel);
		case (sel)
			`SSWD_SEL_T1: sel_cycles = CNT_W'(T1_CYCLES);
			`SSWD_SEL_T2: sel_cycles = CNT_W'(T2_CYCLES);
			`SSWD_SEL_T3: sel_cycles = CNT_W'(T3_CYCLES);
			default: sel_cycles = CNT_W'(T4_CYCLES);
		endcase
	endfunction

	sswd_pkg::sswd_state_t state_q;

	// Strap sampled only in RUN, so a moving pin cannot shorten a running timeout
	logic [1:0] sel_q;
	always_ff @(posedge clock_in) begin
		if (rst_in) sel_q <= `SSWD_SEL_T3;
		else if (state_q != sswd_pkg::SSWD_ST_RUN) sel_q <= sel_q;
		else sel_q <= timeout_select_in;
	end

	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	logic strobe_prev_q;
	logic [CNT_W-1:0] wd_cnt_q;
	logic wd_over_s;
	logic strobe_edge_s;

	assign strobe_edge_s = strobe_s ^ strobe_prev_q;
	assign wd_over_s = (wd_cnt_q == CNT_W'(WDOG_CYCLES) - ONE) && !strobe_edge_s && !float_s;

	always_ff @(posedge clock_in) begin
		if (rst_in) strobe_prev_q <= 1'b0;
		else strobe_prev_q <= strobe_s;
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) wd_cnt_q <= '0;
		else if (state_q != sswd_pkg::SSWD_ST_RUN || manual_s || strobe_edge_s) wd_cnt_q <= '0;
		else if (float_s) wd_cnt_q <= '0;
		else if (wd_over_s) wd_cnt_q <= '0;
		else wd_cnt_q <= wd_cnt_q + ONE;
	end

	// ----------------------------------------
	// Reset sequencing
	// ----------------------------------------
	logic [CNT_W-1:0] to_cnt_q;
	logic to_done_s;
	assign to_done_s = (to_cnt_q >= sel_cycles(sel_q) - ONE);

	always_ff @(posedge clock_in) begin
		if (rst_in) state_q <= sswd_pkg::SSWD_ST_SUPPLY_LOW;
		else if (any_low_s || manual_s) state_q <= sswd_pkg::SSWD_ST_SUPPLY_LOW;
		else begin
			case (state_q)
				sswd_pkg::SSWD_ST_SUPPLY_LOW: state_q <= sswd_pkg::SSWD_ST_HOLD;
				sswd_pkg::SSWD_ST_HOLD:
					if (to_done_s) state_q <= sswd_pkg::SSWD_ST_RUN;
				sswd_pkg::SSWD_ST_RUN:
					if (wd_over_s) state_q <= sswd_pkg::SSWD_ST_WDOG_PULSE;
				sswd_pkg::SSWD_ST_WDOG_PULSE:
					if (to_done_s) state_q <= sswd_pkg::SSWD_ST_RUN;
				default: state_q <= sswd_pkg::SSWD_ST_SUPPLY_LOW;
			endcase
		end
	end

	// Counts only in the timed states; restarts on every drop
	always_ff @(posedge clock_in) begin
		if (rst_in) to_cnt_q <= '0;
		else if (state_q == sswd_pkg::SSWD_ST_SUPPLY_LOW || state_q == sswd_pkg::SSWD_ST_RUN) to_cnt_q <= '0;
		else if (to_done_s) to_cnt_q <= '0;
		else to_cnt_q <= to_cnt_q + ONE;
	end

	// ----------------------------------------
	// Output pins
	// ----------------------------------------
	logic rst_act_d;
	// One cycle ahead of state so the pin follows the state register directly
	always_comb begin
		rst_act_d = 1'b1;
		if (!(any_low_s || manual_s)) begin
			case (state_q)
				sswd_pkg::SSWD_ST_HOLD: rst_act_d = !to_done_s;
				sswd_pkg::SSWD_ST_RUN: rst_act_d = wd_over_s;
				sswd_pkg::SSWD_ST_WDOG_PULSE: rst_act_d = !to_done_s;
				default: rst_act_d = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			reset_asserted_out <= 1'b1;
			sys_reset_out_low_out <= 1'b0;
			sys_reset_oe_out <= 1'b1;
		end else begin
			reset_asserted_out <= rst_act_d;
			sys_reset_out_low_out <= rst_act_d ~^ reset_active_high_in;
			// Open drain only pulls toward its active level, high or low as reset_active_high_in sets
			sys_reset_oe_out <= !reset_open_drain_in || rst_act_d;
		end
	end

	// Power fail is independent of the reset sequence
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			power_fail_out_n_out <= 1'b0;
			power_fail_oe_out <= 1'b0;
		end else begin
			power_fail_out_n_out <= 1'b0;
			power_fail_oe_out <= pf_low_s;
		end
	end
endmodule // sswd_supervisor

/* sswd_supervisor_props.sv */
// Port checker for the supply supervisor.
// Assumes it is bound to sswd_supervisor with the short timeouts of the bench.
module sswd_supervisor_props #(
	parameter int unsigned T1_CYCLES = 20,
	parameter int unsigned T4_CYCLES = 160,
	parameter int unsigned WDOG_CYCLES = 300
) (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic supply_one_low_in,
	input wire logic supply_two_low_in,
	input wire logic supply_three_low_in,
	input wire logic power_fail_sense_in,
	input wire logic watchdog_strobe_in,
	input wire logic watchdog_float_in,
	input wire logic manual_reset_in,
	input wire logic reset_active_high_in,
	input wire logic reset_open_drain_in,
	input wire logic sys_reset_out_low_out,
	input wire logic sys_reset_oe_out,
	input wire logic reset_asserted_out,
	input wire logic power_fail_oe_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic low_w;
	logic strobe_q;
	logic [15:0] good_q, quiet_q, held_q;
	assign low_w = supply_one_low_in | supply_two_low_in | supply_three_low_in | manual_reset_in;
	always_ff @(posedge clock_in) strobe_q <= watchdog_strobe_in;
	// Saturate so a long quiet run cannot wrap back below the figures
	always_ff @(posedge clock_in) good_q <= (rst_in || low_w) ? 16'h0 : good_q + 16'(good_q != 16'hffff);
	always_ff @(posedge clock_in) held_q <= (rst_in || low_w || !reset_asserted_out) ? 16'h0 : held_q + 16'h1;
	always_ff @(posedge clock_in)
		quiet_q <= (rst_in || reset_asserted_out || watchdog_float_in || watchdog_strobe_in != strobe_q) ? 16'h0
			: quiet_q + 16'(quiet_q != 16'hffff);
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	sequence s_pf_rise; $rose(power_fail_sense_in) ##1 power_fail_sense_in [*2]; endsequence
	sequence s_pf_fall; $fell(power_fail_sense_in) ##1 !power_fail_sense_in [*2]; endsequence
	chk_low_asserts: assert property ($rose(low_w) ##1 low_w [*3] |-> ##[0:2] reset_asserted_out)
		else $error("reset flag not raised after supply low");
	chk_hold_time: assert property ($fell(reset_asserted_out) |-> good_q >= T1_CYCLES)
		else $error("reset released before timeout");
	chk_pulse_bound: assert property (held_q <= T4_CYCLES + 6)
		else $error("reset held past longest timeout");
	chk_wdog_quiet: assert property ($rose(reset_asserted_out) && good_q > 16'h8 |-> quiet_q >= WDOG_CYCLES - 2)
		else $error("watchdog reset while strobe serviced");
	chk_wdog_fires: assert property (quiet_q <= WDOG_CYCLES + 6)
		else $error("watchdog did not fire");
	chk_pf_assert: assert property (s_pf_rise |-> ##[0:3] power_fail_oe_out)
		else $error("power fail not driven");
	chk_pf_release: assert property (s_pf_fall |-> ##[0:3] !power_fail_oe_out)
		else $error("power fail not released");
	chk_pin_level: assert property (!$past(rst_in) && $stable(reset_active_high_in)
		|-> sys_reset_out_low_out == (reset_asserted_out ~^ reset_active_high_in)) else $error("reset pin level wrong");
	chk_pin_drive: assert property (!$past(rst_in) && $stable(reset_open_drain_in)
		|-> sys_reset_oe_out == (reset_asserted_out || !reset_open_drain_in)) else $error("reset pin drive wrong");
endmodule // sswd_supervisor_props

/* sswd_sync.sv */
// Two-flop synchroniser for a vector of asynchronous levels.
// Assumes inputs are quasi-static levels from comparators or pins.
module sswd_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_in,
	// Levels
	input wire logic [WIDTH-1:0] async_in,
	input wire logic [WIDTH-1:0] reset_val_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	if (WIDTH < 1) begin : g_width_check
		$error("sswd_sync: WIDTH must be at least 1");
	end

	// Reset value must be a constant tie-off at the instance
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			meta_q <= reset_val_in;
			sync_out <= reset_val_in;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule // sswd_sync

/* testbench.sv */
// Self-checking bench for sswd_supervisor with shortened timeouts.
// Assumes sswd_host stands in for the processor on the strobe pin.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TC[4] = '{20, 40, 80, 160};
	logic clock_in = 1'b0, rst_in = 1'b1, power_fail_sense_in = 1'b0, manual_reset_in = 1'b0;
	logic supply_one_low_in = 1'b0, supply_two_low_in = 1'b0, supply_three_low_in = 1'b0;
	logic reset_active_high_in = 1'b0, reset_open_drain_in = 1'b0, watchdog_strobe_in, watchdog_float_in;
	logic [1:0] timeout_select_in = 2'h0, mode = 2'h1;
	logic [9:0] period = 10'h0fa;
	logic sys_reset_out_low_out, sys_reset_oe_out, reset_asserted_out, power_fail_out_n_out, power_fail_oe_out;
	int miscompares = 0, n_tests = 0, n;
	always #12.5 clock_in = ~clock_in;
	sswd_supervisor #(.T1_CYCLES(20), .T2_CYCLES(40), .T3_CYCLES(80), .T4_CYCLES(160), .WDOG_CYCLES(300)) DUT (.*);
	sswd_host host (.clock_in(clock_in), .mode_in(mode), .period_in(period), .strobe_out(watchdog_strobe_in),
		.float_out(watchdog_float_in));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge clock_in);
	endtask
	task automatic until_flag(input logic v);
		n = 0;
		while (reset_asserted_out !== v && n < 2000) begin
			cyc(1);
			n++;
		end
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic t_select();
		for (int k = 0; k < 4; k++) begin
			timeout_select_in <= 2'(k);
			cyc(3);
			{supply_three_low_in, supply_two_low_in, supply_one_low_in} <= 3'h1 << (k % 3);
			cyc(6);
			check("supply low", reset_asserted_out, 1'b1);
			{supply_three_low_in, supply_two_low_in, supply_one_low_in} <= 3'h0;
			until_flag(1'b0);
			check("hold time", n >= TC[k] && n <= TC[k] + 6, 1'b1);
		end
		$display("t_select done");
	endtask
	task automatic t_restart();
		timeout_select_in <= 2'h0;
		cyc(3);
		supply_two_low_in <= 1'b1;
		cyc(6);
		supply_two_low_in <= 1'b0;
		cyc(12);
		manual_reset_in <= 1'b1;
		cyc(3);
		manual_reset_in <= 1'b0;
		until_flag(1'b0);
		check("restart", n >= 20 && n <= 26, 1'b1);
		supply_one_low_in <= 1'b1;
		cyc(6);
		supply_one_low_in <= 1'b0;
		cyc(12);
		supply_three_low_in <= 1'b1;
		cyc(3);
		supply_three_low_in <= 1'b0;
		until_flag(1'b0);
		check("restart drop", n >= 20 && n <= 26, 1'b1);
		$display("t_restart done");
	endtask
	task automatic t_watchdog();
		cyc(700);
		check("serviced", reset_asserted_out, 1'b0);
		period <= 10'h005;
		cyc(400);
		check("fast strobe", reset_asserted_out, 1'b0);
		mode <= 2'h0;
		until_flag(1'b1);
		check("wdog period", n >= 296 && n <= 306, 1'b1);
		check("pulse pin", sys_reset_out_low_out, reset_active_high_in);
		until_flag(1'b0);
		check("pulse len", n >= 18 && n <= 22, 1'b1);
		mode <= 2'h2;
		cyc(700);
		check("floating", reset_asserted_out, 1'b0);
		mode <= 2'h1;
		$display("t_watchdog done");
	endtask
	task automatic t_pins();
		for (int p = 0; p < 4; p++) begin
			{reset_active_high_in, reset_open_drain_in} <= 2'(p);
			supply_three_low_in <= 1'b1;
			power_fail_sense_in <= p[0];
			cyc(6);
			check("pin on", {sys_reset_out_low_out, sys_reset_oe_out}, {p[1], 1'b1});
			check("pf", {power_fail_oe_out, power_fail_out_n_out}, {p[0], 1'b0});
			supply_three_low_in <= 1'b0;
			until_flag(1'b0);
			cyc(2);
			check("pin off", {sys_reset_out_low_out, sys_reset_oe_out}, {~p[1], ~p[0]});
		end
		power_fail_sense_in <= 1'b0;
		$display("t_pins done");
	endtask
	initial begin
		cyc(2);
		rst_in <= 1'b0;
		until_flag(1'b0);
		check("default hold", n >= 80 && n <= 86, 1'b1);
		t_select();
		t_restart();
		t_watchdog();
		t_pins();
		finish_test();
	end
	initial begin
		cyc(20000);
		miscompares++;
		finish_test();
	end
endmodule // testbench
bind sswd_supervisor sswd_supervisor_props #(.T1_CYCLES(T1_CYCLES), .T4_CYCLES(T4_CYCLES),
	.WDOG_CYCLES(WDOG_CYCLES)) u_props (.*);
